/* src/bss_pkg.sv */
package bss_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SLEEP_TIME_NS  = 150000;
    localparam int SLEEP_CYC      = (SLEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MINOFF_TIME_NS = 85;
    localparam int MINOFF_CYC     = (MINOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_LIMIT       = 120;
    localparam int SYNC_W         = 22;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_HICCUPS   = 8'h08;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          CTRL_HIC_BIT  = 0;
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_PG_BIT     = 5;
    localparam int          ST_SUPPLY_BIT = 6;
    localparam int          ST_HICEN_BIT  = 7;
    localparam int          ST_OV_BIT     = 8;
    localparam int          ST_PGPIN_BIT  = 9;
    localparam int          ST_IGNPIN_BIT = 10;
    localparam int          ST_SLEEP_BIT  = 11;
    localparam int          ST_OCCNT_LSB  = 16;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        BSS_SLEEP  = 5'b00001,
        BSS_OFF    = 5'b00010,
        BSS_START  = 5'b00100,
        BSS_RUN    = 5'b01000,
        BSS_HICCUP = 5'b10000
    } bss_state_t;

    typedef enum logic [1:0] {
        BSS_DIV1 = 2'h0,
        BSS_DIV2 = 2'h1,
        BSS_DIV4 = 2'h2
    } bss_fold_t;

endpackage : bss_pkg

/* src/bss_sync.sv */
module bss_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import bss_pkg::*;

    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : bss_sync

/* src/bss_fold_div.sv */
module bss_fold_div (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rstn,
    // oscillator tick and fold-back ratio
    input  wire logic               osc_tick,
    input  wire bss_pkg::bss_fold_t fold,
    // start of a switching cycle
    output logic                    cycle_start
);
    import bss_pkg::*;

    logic [1:0] cnt_q;

    function automatic logic [1:0] last_count(input bss_fold_t f);
        case (f)
            BSS_DIV4: last_count = 2'h3;
            BSS_DIV2: last_count = 2'h1;
            default:  last_count = 2'h0;
        endcase
    endfunction : last_count

    // every, every second or every fourth oscillator tick opens a cycle, set by fold
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q       <= 2'h0;
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= 1'b0;
            if (osc_tick) begin
                if (cnt_q >= last_count(fold)) begin
                    cnt_q       <= 2'h0;
                    cycle_start <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end

endmodule : bss_fold_div

/* src/bss_top.sv */
// The register offsets and the plain strobed port were left to the implementer.
module bss_top #(
    parameter int SLEEP_CYC_P = bss_pkg::SLEEP_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // enable pins
    input  wire logic        en_logic,
    input  wire logic        ignition_enable_input,
    input  wire logic        ignition_enable_status_output_in,
    output logic             ignition_enable_status_output_out,
    output logic             ignition_enable_status_output_oe,
    // supply and internal rail comparators
    input  wire logic        supply_above_start,
    input  wire logic        supply_above_stop,
    input  wire logic        internal_rail_ok,
    // oscillator
    input  wire logic        osc_pulse,
    // feedback comparators
    input  wire logic        fb_above_200,
    input  wire logic        fb_above_400,
    input  wire logic        fb_above_735,
    input  wire logic        fb_above_750,
    input  wire logic        fb_above_880,
    // soft-start and error amp comparators
    input  wire logic        ss_above_offset,
    input  wire logic        ss_above_fb_offset,
    input  wire logic        ss_above_handover,
    input  wire logic        ss_above_hiccup,
    input  wire logic        ss_below_reset,
    input  wire logic        comp_above_pedestal,
    // current comparators
    input  wire logic        pwm_comp_trip,
    input  wire logic        overcurrent_threshold_trip,
    // power-good delay and pin
    input  wire logic        delay_capacitor_threshold_reached,
    output logic             delay_capacitor_charge_en,
    input  wire logic        power_good_output_in,
    output logic             power_good_output_out,
    output logic             power_good_output_oe,
    // analog controls
    output logic             ss_charge_en,
    output logic             ss_sink_en,
    output logic             ss_discharge_en,
    output logic             comp_pull_low,
    output logic             ref_select_internal,
    output logic             high_side_on,
    output logic             low_side_on
);
    import bss_pkg::*;

    localparam int SLW = $clog2(SLEEP_CYC_P + 1);

    if (SLEEP_CYC_P < 2) begin : g_chk
        $error("SLEEP_CYC_P must be at least 2");
    end

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic en_s, ign_s, sup_start_s, sup_stop_s, rail_s, osc_s;
    logic fb200_s, fb400_s, fb735_s, fb750_s, ov_s;
    logic ss_off_s, ss_pre_s, ss_ref_s, ss_hic_s, ss_rst_s, comp_s;
    logic pwm_trip_s, oc_s, cap_s, pg_pin_s, ign_pin_s;
    logic [SYNC_W-1:0] sync_out;

    bss_sync #(.W(SYNC_W)) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .d    ({en_logic, ignition_enable_input, supply_above_start,
                supply_above_stop, internal_rail_ok, osc_pulse, fb_above_200,
                fb_above_400, fb_above_735, fb_above_750, fb_above_880,
                ss_above_offset, ss_above_fb_offset, ss_above_handover,
                ss_above_hiccup, ss_below_reset, comp_above_pedestal,
                pwm_comp_trip, overcurrent_threshold_trip,
                delay_capacitor_threshold_reached, power_good_output_in,
                ignition_enable_status_output_in}),
        .q    (sync_out)
    );

    assign {en_s, ign_s, sup_start_s, sup_stop_s, rail_s, osc_s, fb200_s,
            fb400_s, fb735_s, fb750_s, ov_s, ss_off_s, ss_pre_s, ss_ref_s,
            ss_hic_s, ss_rst_s, comp_s, pwm_trip_s, oc_s, cap_s, pg_pin_s,
            ign_pin_s} = sync_out;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    bss_state_t state_q;
    logic [31:0] ctrl_q;
    logic [15:0] hiccups_q;
    logic [7:0]  oc_cnt_q;
    logic        supply_ok_q;
    logic        sleep_q;
    logic        pg_rel_q;
    logic        hic_en;
    logic        enter_hiccup;

    assign hic_en       = ss_hic_s & ctrl_q[CTRL_HIC_BIT];
    assign enter_hiccup = (state_q == BSS_RUN) && (oc_cnt_q > 8'(OC_LIMIT));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RESET;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= reg_wdata & CTRL_RESET;
        end
    end

    // a write clears the count; a hiccup in the same cycle still counts
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hiccups_q <= 16'h0000;
        end else if (enter_hiccup) begin
            if (reg_wr && reg_addr == REG_HICCUPS) begin
                hiccups_q <= 16'h0001;
            end else if (hiccups_q != 16'hFFFF) begin
                hiccups_q <= hiccups_q + 16'h0001;
            end
        end else if (reg_wr && reg_addr == REG_HICCUPS) begin
            hiccups_q <= 16'h0000;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    REG_CTRL:    reg_rdata <= ctrl_q;
                    REG_STATUS: begin
                        reg_rdata[ST_STATE_LSB +: 5] <= state_q;
                        reg_rdata[ST_PG_BIT]         <= pg_rel_q;
                        reg_rdata[ST_SUPPLY_BIT]     <= supply_ok_q;
                        reg_rdata[ST_HICEN_BIT]      <= hic_en;
                        reg_rdata[ST_OV_BIT]         <= ov_s;
                        reg_rdata[ST_PGPIN_BIT]      <= pg_pin_s;
                        reg_rdata[ST_IGNPIN_BIT]     <= ign_pin_s;
                        reg_rdata[ST_SLEEP_BIT]      <= sleep_q;
                        reg_rdata[ST_OCCNT_LSB +: 8] <= oc_cnt_q;
                    end
                    REG_HICCUPS: reg_rdata <= {16'h0000, hiccups_q};
                    default:     reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // enable, supply lockout and sleep
    // ----------------------------------------------------------------
    logic           en_any;
    logic [SLW-1:0] sleep_cnt_q;
    logic           active;

    assign en_any = en_s | ign_s;
    assign active = en_any && supply_ok_q && !sleep_q;

    // start comparator sets, stop comparator clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            supply_ok_q <= 1'b0;
        end else if (sup_start_s) begin
            supply_ok_q <= 1'b1;
        end else if (!sup_stop_s) begin
            supply_ok_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sleep_cnt_q <= '0;
        end else if (en_any) begin
            sleep_cnt_q <= '0;
        end else if (sleep_cnt_q != SLW'(SLEEP_CYC_P)) begin
            sleep_cnt_q <= sleep_cnt_q + SLW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sleep_q <= 1'b0;
        end else if (en_any) begin
            sleep_q <= 1'b0;
        end else if (sleep_cnt_q == SLW'(SLEEP_CYC_P)) begin
            sleep_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= BSS_OFF;
        end else if (sleep_q && !en_any) begin
            state_q <= BSS_SLEEP;
        end else if (!active && state_q != BSS_SLEEP) begin
            state_q <= BSS_OFF;
        end else begin
            case (state_q)
                BSS_SLEEP:  if (en_any) state_q <= BSS_OFF;
                BSS_OFF:    if (active) state_q <= BSS_START;
                BSS_START: begin
                    if (ss_off_s && ss_pre_s && comp_s) begin
                        state_q <= BSS_RUN;
                    end
                end
                BSS_RUN:    if (enter_hiccup) state_q <= BSS_HICCUP;
                BSS_HICCUP: if (ss_rst_s) state_q <= BSS_START;
                default:    state_q <= BSS_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // soft-start and error amp controls
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ss_charge_en        <= 1'b0;
            ss_sink_en          <= 1'b0;
            ss_discharge_en     <= 1'b1;
            comp_pull_low       <= 1'b1;
            ref_select_internal <= 1'b0;
        end else begin
            ss_charge_en    <= (state_q == BSS_START) || (state_q == BSS_RUN);
            ss_sink_en      <= (state_q == BSS_HICCUP);
            ss_discharge_en <= (state_q == BSS_OFF) || (state_q == BSS_SLEEP);
            // overvoltage does not touch these
            comp_pull_low   <= !((state_q == BSS_START) || (state_q == BSS_RUN));
            ref_select_internal <= ss_ref_s;
        end
    end

    // ----------------------------------------------------------------
    // frequency fold-back and switching cycle
    // ----------------------------------------------------------------
    bss_fold_t fold_q;
    logic      osc_prev_q;
    logic      cycle_start;
    logic      cycle_start_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fold_q     <= BSS_DIV4;
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
            if (!fb200_s) begin
                fold_q <= BSS_DIV4;
            end else if (!fb400_s) begin
                fold_q <= BSS_DIV2;
            end else begin
                fold_q <= BSS_DIV1;
            end
        end
    end

    bss_fold_div u_fold (
        .mclk        (mclk),
        .rstn        (rstn),
        .osc_tick    (osc_s & ~osc_prev_q),
        .fold        (fold_q),
        .cycle_start (cycle_start)
    );

    // ----------------------------------------------------------------
    // gate drive
    // ----------------------------------------------------------------
    logic       run;
    logic [3:0] minoff_q;
    logic       oc_seen_q;

    assign run = (state_q == BSS_RUN);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cycle_start_q <= 1'b0;
            minoff_q      <= 4'h0;
        end else begin
            cycle_start_q <= cycle_start;
            if (cycle_start_q && ov_s) begin
                minoff_q <= 4'(MINOFF_CYC);
            end else if (minoff_q != 4'h0) begin
                minoff_q <= minoff_q - 4'h1;
            end
        end
    end

    // high side opens one cycle after the low side has dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            high_side_on <= 1'b0;
        end else if (!run || ov_s) begin
            high_side_on <= 1'b0;
        end else if (oc_s || pwm_trip_s) begin
            high_side_on <= 1'b0;
        end else if (cycle_start_q) begin
            high_side_on <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_side_on <= 1'b0;
        end else if (!run || cycle_start || cycle_start_q) begin
            low_side_on <= 1'b0;
        end else if (ov_s) begin
            low_side_on <= (minoff_q != 4'h0);
        end else begin
            low_side_on <= !high_side_on;
        end
    end

    // ----------------------------------------------------------------
    // consecutive overcurrent count
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            oc_seen_q <= 1'b0;
        end else if (oc_s && run) begin
            oc_seen_q <= 1'b1;
        end else if (cycle_start) begin
            oc_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            oc_cnt_q <= 8'h00;
        end else if (!hic_en || !run) begin
            oc_cnt_q <= 8'h00;
        end else if (cycle_start) begin
            if (!oc_seen_q) begin
                oc_cnt_q <= 8'h00;
            end else if (oc_cnt_q != 8'hFF) begin
                oc_cnt_q <= oc_cnt_q + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // power-good and ignition status
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            delay_capacitor_charge_en <= 1'b0;
        end else if (!run || !fb735_s) begin
            delay_capacitor_charge_en <= 1'b0;
        end else if (fb750_s) begin
            delay_capacitor_charge_en <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pg_rel_q <= 1'b0;
        end else begin
            pg_rel_q <= delay_capacitor_charge_en && cap_s && fb735_s && !ov_s;
        end
    end

    // open-drain: the pin is only ever pulled low
    assign power_good_output_out             = 1'b0;
    assign ignition_enable_status_output_out = 1'b0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            power_good_output_oe            <= 1'b1;
            ignition_enable_status_output_oe <= 1'b1;
        end else begin
            if (state_q == BSS_SLEEP) begin
                power_good_output_oe <= rail_s;
            end else begin
                power_good_output_oe <= !pg_rel_q;
            end
            ignition_enable_status_output_oe <= !ign_s;
        end
    end

endmodule : bss_top

/* verification/bss_host.sv */
module bss_host (
    // host request
    input  wire logic mclk,
    input  wire logic en_req,
    // open-drain pins
    input  wire logic power_good_output_oe,
    input  wire logic power_good_output_out,
    input  wire logic ignition_enable_status_output_oe,
    input  wire logic ignition_enable_status_output_out,
    output logic      power_good_output_in,
    output logic      ignition_enable_status_output_in,
    // logic enable
    output logic      en_logic
);
    timeunit 1ns;
    timeprecision 100ps;
    // pull-ups: a released pin reads high
    assign power_good_output_in = power_good_output_oe ? power_good_output_out : 1'h1;
    assign ignition_enable_status_output_in = ignition_enable_status_output_oe ?
        ignition_enable_status_output_out : 1'h1;
    initial en_logic = 1'h0;
    always @(posedge mclk) en_logic <= en_req;
endmodule : bss_host

/* verification/bss_top_assertions.sv */
module bss_top_chk (
    // watched ports
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        ignition_enable_input,
    input wire logic        ignition_enable_status_output_oe,
    input wire logic        supply_above_stop,
    input wire logic        internal_rail_ok,
    input wire logic        fb_above_735,
    input wire logic        fb_above_880,
    input wire logic        ss_below_reset,
    input wire logic        overcurrent_threshold_trip,
    input wire logic        delay_capacitor_threshold_reached,
    input wire logic        power_good_output_oe,
    input wire logic        ss_charge_en,
    input wire logic        ss_sink_en,
    input wire logic        comp_pull_low,
    input wire logic        high_side_on
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence ov_s; (fb_above_880 && internal_rail_ok) [*5]; endsequence
    sequence oc_s; overcurrent_threshold_trip [*2] ##0 high_side_on; endsequence
    ign_status_a: assert property ($stable(ignition_enable_input) [*5] |->
        ignition_enable_status_output_oe == !ignition_enable_input) else $error("ign status");
    oc_cut_a: assert property (oc_s |-> ##2 !high_side_on) else $error("oc cut");
    supply_off_a: assert property ((!supply_above_stop) [*6] |->
        comp_pull_low && !high_side_on) else $error("supply off");
    ov_hold_a: assert property (ov_s |-> power_good_output_oe && !high_side_on)
        else $error("ov hold");
    hiccup_hold_a: assert property ($rose(ss_sink_en) |-> ##[0:2]
        (comp_pull_low && !ss_charge_en && !high_side_on)) else $error("hiccup hold");
    hiccup_exit_a: assert property (ss_below_reset [*4] ##0 ss_sink_en |->
        ##[1:3] !ss_sink_en) else $error("hiccup exit");
    pg_window_a: assert property ((!fb_above_735 && internal_rail_ok) [*5] |->
        power_good_output_oe) else $error("pg window");
    pg_delay_a: assert property ((!delay_capacitor_threshold_reached && internal_rail_ok)
        [*5] |-> power_good_output_oe) else $error("pg delay");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rd idle");
endmodule : bss_top_chk
bind bss_top bss_top_chk u_chk (.*);

/* verification/bss_top_test.sv */
module bss_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import bss_pkg::*;
    localparam int SLP = 20;
    logic mclk = '0, rstn = '0, en_req = '0, reg_wr = '0, reg_rd = '0, osc_pulse = '0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic ignition_enable_input = '0, supply_above_start = '0, supply_above_stop = '0;
    logic internal_rail_ok = '0, fb_above_200 = '0, fb_above_400 = '0, fb_above_735 = '0;
    logic fb_above_750 = '0, fb_above_880 = '0, ss_above_offset = '0, ss_above_fb_offset = '0;
    logic ss_above_handover = '0, ss_above_hiccup = '0, ss_below_reset = '0;
    logic comp_above_pedestal = '0, pwm_comp_trip = '0, overcurrent_threshold_trip = '0;
    logic delay_capacitor_threshold_reached = '0, delay_capacitor_charge_en, en_logic;
    logic ignition_enable_status_output_in, ignition_enable_status_output_out;
    logic ignition_enable_status_output_oe, power_good_output_in, power_good_output_out;
    logic power_good_output_oe, ss_charge_en, ss_sink_en, ss_discharge_en, comp_pull_low;
    logic ref_select_internal, high_side_on, low_side_on;
    logic [3:0] osc_div = '0;
    int mismatches = 0, checks_done = 0, seed = 47, falls = 0, lows = 0;
    bss_top #(.SLEEP_CYC_P(SLP)) dut (.*);
    bss_host host (.*);
    initial forever #5 mclk = ~mclk;
    // oscillator tick every 16 clocks
    always @(posedge mclk) begin
        osc_div <= osc_div + 4'h1;
        osc_pulse <= osc_div[3];
        lows += low_side_on;
    end
    always @(negedge low_side_on) falls++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata & m, e);
        @(posedge mclk);
    endtask : rd
    // model: one switching cycle per 1, 2 or 4 ticks
    task automatic fold(input int lvl);
        fb_above_200 <= lvl > 0;
        fb_above_400 <= lvl > 1;
        cyc(40);
        falls = 0;
        cyc(512);
        chk(falls, 32 >> (2 - lvl));
    endtask : fold
    task automatic report_and_stop;
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        #150000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        cyc(20);
        rstn <= 1'h1;
        chk(comp_pull_low, 1'h1);
        rd(REG_CTRL, 32'hFFFFFFFF, CTRL_RESET);
        rd(8'h0C, 32'hFFFFFFFF, 32'h0);
        wr(REG_CTRL, 32'h0);
        rd(REG_CTRL, 32'hFFFFFFFF, 32'h0);
        wr(REG_CTRL, 32'h1);
        supply_above_start <= 1'h1;
        supply_above_stop <= 1'h1;
        internal_rail_ok <= 1'h1;
        ignition_enable_input <= 1'h1;
        cyc(8);
        chk(ignition_enable_status_output_in, 1'h1);
        chk(ss_charge_en, 1'h1);
        en_req <= 1'h1;
        ignition_enable_input <= 1'h0;
        cyc(8);
        chk(ignition_enable_status_output_in, 1'h0);
        pwm_comp_trip <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            {ss_above_offset, ss_above_fb_offset, comp_above_pedestal} <= i[2:0];
            cyc(8);
            rd(REG_STATUS, 32'h1F, i == 7 ? 32'h8 : 32'h4);
        end
        pwm_comp_trip <= 1'h0;
        cyc(80);
        chk(high_side_on, 1'h1);
        overcurrent_threshold_trip <= 1'h1;
        cyc(8);
        chk(high_side_on, 1'h0);
        overcurrent_threshold_trip <= 1'h0;
        cyc(80);
        chk(high_side_on, 1'h1);
        pwm_comp_trip <= 1'h1;
        ss_above_handover <= 1'h1;
        cyc(8);
        chk(ref_select_internal, 1'h1);
        repeat (2) fold({$random(seed)} % 3);
        for (int i = 0; i < 3; i++) fold(i);
        fb_above_735 <= 1'h1;
        fb_above_750 <= 1'h1;
        cyc(8);
        chk(delay_capacitor_charge_en, 1'h1);
        chk(power_good_output_in, 1'h0);
        delay_capacitor_threshold_reached <= 1'h1;
        cyc(8);
        chk(power_good_output_in, 1'h1);
        fb_above_880 <= 1'h1;
        cyc(40);
        lows = 0;
        cyc(256);
        chk(lows, 16 * MINOFF_CYC);
        chk(power_good_output_in, 1'h0);
        fb_above_880 <= 1'h0;
        cyc(8);
        chk(power_good_output_in, 1'h1);
        rd(REG_STATUS, 32'h1F, 32'h8);
        overcurrent_threshold_trip <= 1'h1;
        cyc(16 * 130);
        rd(REG_STATUS, 32'h1F, 32'h8);
        ss_above_hiccup <= 1'h1;
        cyc(16 * 110);
        rd(REG_STATUS, 32'h1F, 32'h8);
        cyc(16 * 20);
        rd(REG_STATUS, 32'h1F, 32'h10);
        chk(ss_sink_en, 1'h1);
        chk(comp_pull_low, 1'h1);
        rd(REG_HICCUPS, 32'hFFFF, 32'h1);
        wr(REG_HICCUPS, 32'h0);
        rd(REG_HICCUPS, 32'hFFFF, 32'h0);
        {ss_below_reset, ss_above_offset, ss_above_hiccup} <= 3'h4;
        overcurrent_threshold_trip <= 1'h0;
        cyc(8);
        chk(ss_sink_en, 1'h0);
        rd(REG_STATUS, 32'h1F, 32'h4);
        en_req <= 1'h0;
        cyc(SLP - 5);
        en_req <= 1'h1;
        cyc(4);
        en_req <= 1'h0;
        cyc(SLP - 5);
        rd(REG_STATUS, 32'h800, 32'h0);
        cyc(12);
        rd(REG_STATUS, 32'h81F, 32'h801);
        chk(power_good_output_in, 1'h0);
        internal_rail_ok <= 1'h0;
        cyc(6);
        chk(power_good_output_in, 1'h1);
        {supply_above_start, supply_above_stop} <= 2'h0;
        en_req <= 1'h1;
        cyc(8);
        rd(REG_STATUS, 32'h1F, 32'h2);
        chk(ss_discharge_en, 1'h1);
        {supply_above_start, supply_above_stop} <= 2'h3;
        cyc(8);
        supply_above_start <= 1'h0;
        cyc(8);
        rd(REG_STATUS, 32'h1F, 32'h4);
        supply_above_stop <= 1'h0;
        cyc(8);
        rd(REG_STATUS, 32'h1F, 32'h2);
        report_and_stop;
    end
endmodule : bss_top_test
